// ===== inc/pvt_pkg.sv
// constants and types for the peak/valley tracking counter block
// assumes one 100 MHz apb clock; all pins arrive asynchronously
package pvt_pkg;
  localparam int          CODE_W       = 8;          // tracking counter width
  localparam int          DCNT_W       = 6;          // decay-rate counter width
  localparam logic [7:0]  CODE_RESET   = 8'h80;      // mid-scale after reset
  localparam logic [7:0]  CODE_MAX     = 8'hFF;      // saturation ceiling
  localparam logic [7:0]  CODE_MIN     = 8'h00;      // saturation floor
  localparam logic [7:0]  SLOW_ATT     = 8'h02;      // slow attack step
  localparam logic [7:0]  FAST_ATT     = 8'h04;      // fast attack step
  localparam logic [7:0]  FAST_DEC     = 8'h08;      // fast decay step
  localparam logic [7:0]  SLOW_DEC     = 8'h01;      // slow decay step
  localparam logic [5:0]  DCNT_RELOAD  = 6'h28;      // forty cycles
  localparam logic [5:0]  DCNT_MIN     = 6'h01;      // reload after attack
  localparam logic [11:0] ADDR_LEVEL   = 12'h000;    // {valley, peak}
  localparam logic [11:0] ADDR_DECAY   = 12'h004;    // {valley, peak} decay
  localparam logic [11:0] ADDR_CTRL    = 12'h008;    // clear / status
  localparam int          CTRL_CLEAR   = 0;          // write 1 clears counters
  localparam int          ST_MODE_LO   = 0;          // status mode field
  localparam int          ST_TEST0     = 2;          // status test mode 0
  localparam int          ST_STANDBY   = 3;          // status standby
  localparam int          DEC_POS      = 8;          // valley field position
  // operating modes from the two mode-select inputs
  typedef enum logic [1:0] {MODE_OFF, MODE_FAST, MODE_HOLD, MODE_SLOW} mode_t;
  // control inputs latched on the falling device clock edge
  typedef struct packed {
    logic test;
    logic mode_select_a;
    logic mode_select_b;
    logic track_inhibit;
    logic cutoff_select;
    logic offset_ref;
  } ctrl_t;
  // comparator enables from the analog front end
  typedef struct packed {
    logic peak_att;
    logic peak_dec;
    logic val_att;
    logic val_dec;
  } cmp_t;
  // everything that enters through pins
  typedef struct packed {
    logic  dev_clk;
    ctrl_t ctrl;
    cmp_t  cmp;
    logic  adc_msb;
    logic  adc_lsb;
  } pins_t;
endpackage

// ===== src/pvt_counters.sv
// peak and valley tracking counters with decay timers, test mode 0 and apb status
// assumes the device clock and all control pins are asynchronous to pclk
//
// Overview of operation
// - slow mode attack steps two counts
// - slow mode decay steps once per forty
// - attack beats decay in same cycle
// - slow reload: one after attack, forty after decay
// - fast mode attack steps four counts
// - fast mode decay steps eight counts
// - fast mode holds decay timer at one
// - hold mode freezes both counters
// - hold mode holds decay timer at one
// - off mode freezes counters, signals standby
// - off mode holds decay timer at one
// - test high, selects low: test 0
// - test 0: cutoff select resets counters
// - test 0: inhibit sets direction, decay tap
// - test 0: step on rising edges
// - from slow: offset selects both rates
// - from fast: valley rate inverted
// - test 0: dacs routed to level pins
// - mode select decode off/fast/hold/slow
// - eight-bit counters on device clock
// - track inhibit acts as hold
// - controls latched on falling edge
module pvt_counters (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        dev_clk,
  input  wire logic        test,
  input  wire logic        mode_select_a,
  input  wire logic        mode_select_b,
  input  wire logic        track_inhibit,
  input  wire logic        cutoff_select,
  input  wire logic        offset_reference_input,
  input  wire logic        peak_attack,
  input  wire logic        peak_decay,
  input  wire logic        valley_attack,
  input  wire logic        valley_decay,
  input  wire logic        adc_msb,
  input  wire logic        adc_lsb,
  output logic      [7:0]  peak_code,
  output logic      [7:0]  valley_code,
  output logic             standby,
  output logic             filter_wide,
  output logic             level_code_msb,
  output logic             level_code_lsb,
  output logic             level_route_dac,
  output logic      [5:0]  analog_input_pin_o,
  output logic             analog_input_pin_oe_n
);

  localparam int PW = $bits(pvt_pkg::pins_t);

  pvt_pkg::pins_t  pins_raw;                 // pins gathered into one word
  logic [PW-1:0]   s1_q, s2_q, s3_q;         // three-stage synchroniser
  pvt_pkg::pins_t  st_q;                     // filtered pin levels
  logic            clk_prev_q;               // last filtered device clock
  logic            fall_p, rise_p;           // device clock edge events
  logic            step_q;                   // normal step, after a fall
  logic            tstep_q;                  // test step, after a rise
  pvt_pkg::ctrl_t  ctl_q;                    // latched control inputs
  pvt_pkg::cmp_t   cmp_q;                    // latched comparator enables
  pvt_pkg::mode_t  mode;                     // decoded mode
  logic            test0;                    // test mode 0 selected
  logic            tst_rst;                  // test mode 0 counter reset
  logic            run;                      // normal tracking allowed
  logic            entry_fast_q;             // last tracking mode was fast
  logic            clear_q;                  // software clear pulse
  logic [7:0]      code_q [2];               // 0 peak, 1 valley
  logic [5:0]      dcnt_q [2];               // decay-rate counters

  assign pins_raw = '{dev_clk, '{test, mode_select_a, mode_select_b, track_inhibit,
                      cutoff_select, offset_reference_input},
                      '{peak_attack, peak_decay, valley_attack, valley_decay},
                      adc_msb, adc_lsb};

  // saturating step; clamps at the code range limits
  function automatic logic [7:0] sat_move(input logic [7:0] c, input logic [7:0] s,
                                          input logic up);
    logic [8:0] t;
    t = 9'h000;
    if (up) begin
      t = {1'b0, c} + {1'b0, s};
      sat_move = t[8] ? pvt_pkg::CODE_MAX : t[7:0];
    end else begin
      sat_move = (c < s) ? pvt_pkg::CODE_MIN : 8'(c - s);
    end
  endfunction

  // pin synchroniser: stage one feeds only stage two
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= pins_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // accept a pin change once stages two and three agree, per bit
  for (genvar b = 0; b < PW; b++) begin : g_flt
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        st_q[b] <= 1'b0;
      end else if (s2_q[b] == s3_q[b]) begin
        st_q[b] <= s3_q[b];
      end
    end
  end

  // device clock edge detection on the filtered level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_prev_q <= 1'b0;
    end else begin
      clk_prev_q <= st_q.dev_clk;
    end
  end
  assign fall_p = clk_prev_q & ~st_q.dev_clk;
  assign rise_p = ~clk_prev_q & st_q.dev_clk;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q <= '0;
      cmp_q <= '0;
    end else if (fall_p) begin
      ctl_q <= st_q.ctrl;
      cmp_q <= st_q.cmp;
    end
  end

  // steps act one pclk after the edge, so they see the fresh latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_q  <= 1'b0;
      tstep_q <= 1'b0;
    end else begin
      step_q  <= fall_p;
      tstep_q <= rise_p;
    end
  end

  always_comb begin
    case ({ctl_q.mode_select_a, ctl_q.mode_select_b})
      2'b00:   mode = pvt_pkg::MODE_OFF;
      2'b01:   mode = pvt_pkg::MODE_FAST;
      2'b10:   mode = pvt_pkg::MODE_HOLD;
      2'b11:   mode = pvt_pkg::MODE_SLOW;
      default: mode = pvt_pkg::MODE_OFF;
    endcase
  end

  assign test0   = ctl_q.test & ~ctl_q.mode_select_a & ~ctl_q.mode_select_b;
  assign tst_rst = test0 & ctl_q.cutoff_select;
  assign run     = ~ctl_q.test & ~ctl_q.track_inhibit;

  // remember whether test mode 0 was entered from fast or slow
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      entry_fast_q <= 1'b0;
    end else if (!ctl_q.test && mode == pvt_pkg::MODE_FAST) begin
      entry_fast_q <= 1'b1;
    end else if (!ctl_q.test && mode == pvt_pkg::MODE_SLOW) begin
      entry_fast_q <= 1'b0;
    end
  end

  // per-channel counters: index 0 peak tracks up, index 1 valley tracks down
  for (genvar i = 0; i < 2; i++) begin : g_ch
    logic att, dec, tfast;
    logic track_up;                          // attack direction
    assign att      = (i == 0) ? cmp_q.peak_att : cmp_q.val_att;
    assign dec      = (i == 0) ? cmp_q.peak_dec : cmp_q.val_dec;
    assign track_up = (i == 0);
    // rate from offset input; valley inverted after fast
    assign tfast    = (i == 1 && entry_fast_q) ? ~ctl_q.offset_ref : ctl_q.offset_ref;

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        code_q[i] <= pvt_pkg::CODE_RESET;
      end else if (clear_q || tst_rst) begin
        code_q[i] <= pvt_pkg::CODE_RESET;
      end else if (tstep_q && test0) begin
        // test steps on rising edge; inhibit sets direction
        code_q[i] <= sat_move(code_q[i], tfast ? pvt_pkg::FAST_ATT : pvt_pkg::SLOW_ATT,
                              ctl_q.track_inhibit);
      end else if (step_q && run) begin
        // hold and off fall through, leaving the code unchanged
        case (mode)
          pvt_pkg::MODE_SLOW: begin
            if (att) begin
              code_q[i] <= sat_move(code_q[i], pvt_pkg::SLOW_ATT, track_up);
            end else if (dec && dcnt_q[i] == pvt_pkg::DCNT_MIN) begin
              code_q[i] <= sat_move(code_q[i], pvt_pkg::SLOW_DEC, !track_up);
            end
          end
          pvt_pkg::MODE_FAST: begin
            if (att) begin
              code_q[i] <= sat_move(code_q[i], pvt_pkg::FAST_ATT, track_up);
            end else if (dec) begin
              code_q[i] <= sat_move(code_q[i], pvt_pkg::FAST_DEC, !track_up);
            end
          end
          default: begin
          end
        endcase
      end
    end

    // decay-rate counter
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        dcnt_q[i] <= pvt_pkg::DCNT_MIN;
      end else if (clear_q || tst_rst) begin
        dcnt_q[i] <= pvt_pkg::DCNT_MIN;
      end else if (tstep_q && test0) begin
        dcnt_q[i] <= (dcnt_q[i] == pvt_pkg::DCNT_MIN) ? pvt_pkg::DCNT_RELOAD
                                                       : 6'(dcnt_q[i] - 6'h01);
      end else if (step_q && !ctl_q.test) begin
        if (mode != pvt_pkg::MODE_SLOW) begin
          dcnt_q[i] <= pvt_pkg::DCNT_MIN;
        end else if (!ctl_q.track_inhibit) begin
          if (att) begin
            dcnt_q[i] <= pvt_pkg::DCNT_MIN;
          end else if (dec) begin
            dcnt_q[i] <= (dcnt_q[i] == pvt_pkg::DCNT_MIN) ? pvt_pkg::DCNT_RELOAD
                                                           : 6'(dcnt_q[i] - 6'h01);
          end
        end
      end
    end

    // slow attack moves exactly two counts
    slow_att_a: assert property (@(posedge pclk) disable iff (!presetn)
      step_q && run && mode == pvt_pkg::MODE_SLOW && att && !clear_q
      && code_q[i] > 8'h02 && code_q[i] < 8'hFD
      |=> code_q[i] == (track_up ? 8'($past(code_q[i]) + 8'h02) : 8'($past(code_q[i]) - 8'h02)))
      else $error("slow attack step wrong");

    // forty-cycle spacing of slow decay
    slow_dec_a: assert property (@(posedge pclk) disable iff (!presetn)
      step_q && run && mode == pvt_pkg::MODE_SLOW && !att && dec && !clear_q
      && dcnt_q[i] != pvt_pkg::DCNT_MIN |=> $stable(code_q[i]))
      else $error("slow decay fired early");

    // attack wins in fast mode
    att_prio_a: assert property (@(posedge pclk) disable iff (!presetn)
      step_q && run && mode == pvt_pkg::MODE_FAST && att && dec && !clear_q
      && code_q[i] > 8'h08 && code_q[i] < 8'hF7
      |=> code_q[i] == (track_up ? 8'($past(code_q[i]) + 8'h04) : 8'($past(code_q[i]) - 8'h04)))
      else $error("decay beat attack");

    // reload to forty after a slow decay step
    dec_reload_a: assert property (@(posedge pclk) disable iff (!presetn)
      step_q && run && mode == pvt_pkg::MODE_SLOW && !att && dec && !clear_q
      && dcnt_q[i] == pvt_pkg::DCNT_MIN |=> dcnt_q[i] == 6'h28)
      else $error("decay timer not reloaded");

    // fast decay moves eight counts
    fast_dec_a: assert property (@(posedge pclk) disable iff (!presetn)
      step_q && run && mode == pvt_pkg::MODE_FAST && !att && dec && !clear_q
      && code_q[i] > 8'h08 && code_q[i] < 8'hF7
      |=> code_q[i] == (track_up ? 8'($past(code_q[i]) - 8'h08) : 8'($past(code_q[i]) + 8'h08)))
      else $error("fast decay step wrong");

    // hold, off and inhibit freeze the code
    hold_freeze_a: assert property (@(posedge pclk) disable iff (!presetn)
      step_q && !ctl_q.test && !clear_q && (ctl_q.track_inhibit || mode == pvt_pkg::MODE_HOLD
      || mode == pvt_pkg::MODE_OFF) |=> $stable(code_q[i]))
      else $error("code moved while held");

    // non-slow modes keep the timer at one
    timer_one_a: assert property (@(posedge pclk) disable iff (!presetn)
      step_q && !ctl_q.test && mode != pvt_pkg::MODE_SLOW |=> dcnt_q[i] == 6'h01)
      else $error("decay timer not one");

    // no wrap when already at the top or bottom
    sat_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
      step_q && run && mode == pvt_pkg::MODE_FAST && att && !clear_q
      && code_q[i] == (track_up ? 8'hFF : 8'h00) |=> $stable(code_q[i]))
      else $error("counter wrapped");
  end

  // test reset holds counters at reset value
  tst_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
    tst_rst |=> code_q[0] == 8'h80 && code_q[1] == 8'h80)
    else $error("test reset ignored");

  // pin side outputs, all registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      standby               <= 1'b0;
      filter_wide           <= 1'b0;
      level_code_msb        <= 1'b0;
      level_code_lsb        <= 1'b0;
      level_route_dac       <= 1'b0;
      analog_input_pin_o    <= 6'h00;
      analog_input_pin_oe_n <= 1'b1;
      peak_code             <= pvt_pkg::CODE_RESET;
      valley_code           <= pvt_pkg::CODE_RESET;
    end else begin
      // standby in off mode, codes kept
      standby               <= ~ctl_q.test & (mode == pvt_pkg::MODE_OFF);
      filter_wide           <= ctl_q.cutoff_select;
      // dac levels routed onto level pins in test mode 0
      level_route_dac       <= test0;
      level_code_msb        <= test0 ? 1'b0 : st_q.adc_msb;
      level_code_lsb        <= test0 ? 1'b0 : st_q.adc_lsb;
      analog_input_pin_o    <= test0 ? (ctl_q.track_inhibit ? dcnt_q[0] : dcnt_q[1]) : 6'h00;
      analog_input_pin_oe_n <= ~test0;
      peak_code             <= code_q[0];
      valley_code           <= code_q[1];
    end
  end

  // apb slave: zero wait states, error on unmapped address
  logic acc, hit;
  assign acc     = psel & penable;
  assign hit     = (paddr == pvt_pkg::ADDR_LEVEL) || (paddr == pvt_pkg::ADDR_DECAY)
                   || (paddr == pvt_pkg::ADDR_CTRL);
  assign pready  = 1'b1;
  assign pslverr = acc & ~hit;

  // software clear is a one-cycle pulse taken at the access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clear_q <= 1'b0;
    end else begin
      clear_q <= acc & pwrite & (paddr == pvt_pkg::ADDR_CTRL) & pwdata[pvt_pkg::CTRL_CLEAR];
    end
  end

  // read data, combinational from the live state
  always_comb begin
    prdata = 32'h0000_0000;
    if (psel && !pwrite) begin
      case (paddr)
        pvt_pkg::ADDR_LEVEL: prdata = {16'h0000, code_q[1], code_q[0]};
        pvt_pkg::ADDR_DECAY: prdata = {18'h00000, dcnt_q[1], 2'b00, dcnt_q[0]};
        pvt_pkg::ADDR_CTRL:  prdata = {28'h0000000, standby, test0, 2'(mode)};
        default:             prdata = 32'h0000_0000;
      endcase
    end
  end

endmodule // pvt_counters

// ===== tb/pvt_decoder.sv
// symbol decoder model: makes the device clock and drives the control pins
// assumes pclk from the bench; the bench calls the tasks hierarchically
module pvt_decoder (
  input  wire logic pclk,
  output logic      dev_clk,
  output logic      test,
  output logic      mode_select_a,
  output logic      mode_select_b,
  output logic      track_inhibit,
  output logic      cutoff_select,
  output logic      offset_reference_input
);
  timeunit 1ns;
  timeprecision 1ps;

  // pins idle in off mode, clock parked high between symbols
  initial begin
    {dev_clk, test, mode_select_a, mode_select_b} = 4'h8;
    {track_inhibit, cutoff_select, offset_reference_input} = 3'h0;
  end

  // test stays low unless asked for
  // levels settle well before the next falling edge
  task automatic set(input logic t, input pvt_pkg::mode_t m, input logic inh, input logic cut,
                     input logic off);
    {test, mode_select_a, mode_select_b} <= {t, m};
    {track_inhibit, cutoff_select, offset_reference_input} <= {inh, cut, off};
    repeat (8) @(posedge pclk);
  endtask

  // one clock phase, longer than the pin filter needs
  task automatic half(input logic v);
    dev_clk <= v;
    repeat (8) @(posedge pclk);
  endtask

  // whole device clock periods: fall first, then rise
  task automatic tick(input int n);
    repeat (n) begin
      half(1'b0);
      half(1'b1);
    end
  endtask
endmodule // pvt_decoder

// ===== tb/pvt_counters_bench.sv
// self-checking bench for the tracking counters
// assumes zero-wait apb and the decoder model on the pin side
module pvt_counters_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        dev_clk, test, msa, msb, inh, cut, offr;
  logic [3:0]  cmp;             // peak att/dec, valley att/dec
  logic [1:0]  adc;             // msb, lsb
  logic [7:0]  peak_code, valley_code;
  logic        standby, filter_wide, lvl_msb, lvl_lsb, route_dac, tap_oe_n, last_err;
  logic [5:0]  tap;
  int          fails, checks_done;

  pvt_counters pvt_counters_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dev_clk(dev_clk), .test(test), .mode_select_a(msa), .mode_select_b(msb),
    .track_inhibit(inh), .cutoff_select(cut), .offset_reference_input(offr),
    .peak_attack(cmp[3]), .peak_decay(cmp[2]), .valley_attack(cmp[1]), .valley_decay(cmp[0]),
    .adc_msb(adc[1]), .adc_lsb(adc[0]), .peak_code(peak_code), .valley_code(valley_code),
    .standby(standby), .filter_wide(filter_wide), .level_code_msb(lvl_msb),
    .level_code_lsb(lvl_lsb), .level_route_dac(route_dac), .analog_input_pin_o(tap),
    .analog_input_pin_oe_n(tap_oe_n));

  pvt_decoder pvt_decoder_i (.pclk(pclk), .dev_clk(dev_clk), .test(test), .mode_select_a(msa),
    .mode_select_b(msb), .track_inhibit(inh), .cutoff_select(cut), .offset_reference_input(offr));

  // 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // compare and count; unknowns never match
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one apb transfer, entered just after a rising edge; one idle cycle after
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask

  // comparator enables held over n device clocks, then dropped for one pclk
  // so that back-to-back runs never assign the enables twice in one step
  task automatic run(input logic [3:0] e, input int n);
    cmp <= e;
    pvt_decoder_i.tick(n);
    cmp <= 4'h0;
    @(posedge pclk);
  endtask

  // verdict in one place
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // watchdog: the whole run needs well under 5000 cycles
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    summarize();
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, cmp, adc} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(12'h000, 32'h0000_8080);
    rd(12'h004, 32'h0000_0101);
    rd(12'h00C, 32'h0);
    chk(last_err, 1'b1);
    adc <= 2'h2;
    pvt_decoder_i.set(1'b0, pvt_pkg::MODE_SLOW, 1'b0, 1'b0, 1'b0);
    pvt_decoder_i.tick(1);
    rd(12'h008, 32'h3);
    chk({lvl_msb, lvl_lsb}, 2'h2);
    // both adc bits must reach the level pins, and the tap stays released
    adc <= 2'h1;
    repeat (6) @(posedge pclk);
    chk({lvl_msb, lvl_lsb}, 2'h1);
    chk({tap_oe_n, tap}, 7'h40);
    // slow mode attack, then attack beating decay
    run(4'h8, 3);
    run(4'h2, 1);
    rd(12'h000, 32'h0000_7E86);
    run(4'hC, 1);
    chk(peak_code, 8'h88);
    rd(12'h004, 32'h0000_0101);
    // slow decay: one count per forty device clocks
    run(4'h4, 1);
    chk(peak_code, 8'h87);
    rd(12'h004, 32'h0000_0128);
    run(4'h4, 39);
    chk(peak_code, 8'h87);
    run(4'h4, 1);
    chk(peak_code, 8'h86);
    // inhibit blocks both attack enables
    pvt_decoder_i.set(1'b0, pvt_pkg::MODE_SLOW, 1'b1, 1'b0, 1'b0);
    run(4'hA, 2);
    rd(12'h000, 32'h0000_7E86);
    // fast mode steps, timers parked at one, saturation at the top
    pvt_decoder_i.set(1'b0, pvt_pkg::MODE_FAST, 1'b0, 1'b0, 1'b0);
    run(4'h8, 1);
    chk(peak_code, 8'h8A);
    rd(12'h004, 32'h0000_0101);
    run(4'h5, 1);
    rd(12'h000, 32'h0000_8682);
    // attack and decay together in fast mode: attack step only
    run(4'hF, 1);
    rd(12'h000, 32'h0000_8286);
    run(4'h8, 32);
    chk(peak_code, 8'hFF);
    // hold and off freeze the codes
    pvt_decoder_i.set(1'b0, pvt_pkg::MODE_HOLD, 1'b0, 1'b0, 1'b0);
    run(4'h6, 2);
    rd(12'h000, 32'h0000_82FF);
    rd(12'h004, 32'h0000_0101);
    pvt_decoder_i.set(1'b0, pvt_pkg::MODE_OFF, 1'b0, 1'b0, 1'b0);
    run(4'hA, 2);
    rd(12'h008, 32'h8);
    rd(12'h004, 32'h0000_0101);
    pvt_decoder_i.set(1'b0, pvt_pkg::MODE_SLOW, 1'b0, 1'b0, 1'b0);
    run(4'h0, 1);
    rd(12'h000, 32'h0000_82FF);
    chk(standby, 1'b0);
    // clear through the bus, and a write refused at an unmapped place
    apb(1'b1, 12'h008, 32'h1);
    rd(12'h000, 32'h0000_8080);
    apb(1'b1, 12'h010, 32'hFFFF_FFFF);
    chk(last_err, 1'b1);
    // test mode 0 entered from slow: reset, then up on rising edges only
    pvt_decoder_i.set(1'b1, pvt_pkg::MODE_OFF, 1'b1, 1'b1, 1'b0);
    pvt_decoder_i.tick(1);
    rd(12'h008, 32'h4);
    chk({filter_wide, peak_code, valley_code}, 17'h18080);
    pvt_decoder_i.set(1'b1, pvt_pkg::MODE_OFF, 1'b1, 1'b0, 1'b0);
    pvt_decoder_i.half(1'b0);
    chk(peak_code, 8'h80);
    pvt_decoder_i.half(1'b1);
    rd(12'h000, 32'h0000_8282);
    chk({route_dac, tap_oe_n, lvl_msb, lvl_lsb}, 4'h8);
    chk(tap, 32'h28);
    pvt_decoder_i.set(1'b1, pvt_pkg::MODE_OFF, 1'b1, 1'b0, 1'b1);
    pvt_decoder_i.tick(1);
    rd(12'h000, 32'h0000_8686);
    // test mode 0 entered from fast: valley rate inverted, counting down
    pvt_decoder_i.set(1'b0, pvt_pkg::MODE_FAST, 1'b0, 1'b0, 1'b0);
    pvt_decoder_i.tick(1);
    pvt_decoder_i.set(1'b1, pvt_pkg::MODE_OFF, 1'b0, 1'b1, 1'b0);
    pvt_decoder_i.tick(1);
    pvt_decoder_i.set(1'b1, pvt_pkg::MODE_OFF, 1'b0, 1'b0, 1'b0);
    pvt_decoder_i.tick(1);
    rd(12'h000, 32'h0000_7C7E);
    summarize();
  end
endmodule // pvt_counters_bench
